// [hw/vac_pkg.sv]
package vac_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_SYNC_AUX     = 8'h00;
	localparam logic [7:0] ADDR_START_HIGH   = 8'h04;
	localparam logic [7:0] ADDR_START_LOW    = 8'h08;
	localparam logic [7:0] ADDR_PULSE_WIDTH  = 8'h0C;
	localparam logic [7:0] ADDR_CALIB_CONFIG = 8'h10;
	localparam logic [7:0] ADDR_STATUS       = 8'h14;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int FIRST_EDGE_BIT   = 0;
	localparam int SECOND_EDGE_BIT  = 2;
	localparam int PIN_DISABLE_BIT  = 3;
	localparam int PIN_FUNC_LSB     = 4;
	localparam int AUX_DIVIDE_BIT   = 6;
	localparam int AUX_DISABLE_BIT  = 7;
	localparam int CALIB_DIS_BIT    = 0;
	localparam int CALIB_PIX_LSB    = 2;
	localparam int CALIB_TC_LSB     = 4;
	localparam int START_HIGH_W     = 5;
	localparam int START_LOW_W      = 8;
	localparam int START_W          = 13;

	// writable masks: everything else reads zero
	localparam logic [7:0] MASK_SYNC_AUX     = 8'hFD;
	localparam logic [7:0] MASK_START_HIGH   = 8'h1F;
	localparam logic [7:0] MASK_START_LOW    = 8'hFF;
	localparam logic [7:0] MASK_PULSE_WIDTH  = 8'hFF;
	localparam logic [7:0] MASK_CALIB_CONFIG = 8'h7D;

	// reset values
	localparam logic [7:0] RST_SYNC_AUX     = 8'h00;
	localparam logic [7:0] RST_START_HIGH   = 8'h00;
	localparam logic [7:0] RST_START_LOW    = 8'h00;
	localparam logic [7:0] RST_PULSE_WIDTH  = 8'h08;
	localparam logic [7:0] RST_CALIB_CONFIG = 8'h40;

	// clamp width settings below this make no pulse
	localparam logic [7:0] MIN_PULSE_WIDTH = 8'h02;

	// multipurpose pin functions
	typedef enum logic [1:0] {
		VAC_FUNC_INVERT = 2'b00,
		VAC_FUNC_CLAMP  = 2'b01,
		VAC_FUNC_COAST  = 2'b10,
		VAC_FUNC_EXTERNAL_SAMPLE_CLOCK = 2'b11
	} vac_pin_func_t;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int UPDATE_DELAY_MS = 100;
	localparam int UPDATE_DELAY_CYCLES = (UPDATE_DELAY_MS * 1000000) / CLK_PERIOD_NS;

	// black pixels averaged per line: 16 << code
	function automatic logic [7:0] calib_pixels(input logic [1:0] code);
		calib_pixels = 8'h10 << code;
	endfunction : calib_pixels

	// loop time constant in lines: 2 ** (5 + code)
	function automatic logic [12:0] calib_lines(input logic [2:0] code);
		calib_lines = 13'h0020 << code;
	endfunction : calib_lines

endpackage : vac_pkg

// [hw/vac_clamp_if.sv]
interface vac_clamp_if;
	logic                          first_edge_lead;
	logic                          second_edge_lead;
	logic                          sync_select;
	logic [vac_pkg::START_W-1:0]   start_count;
	logic [7:0]                    pulse_length;
	logic                          clamp_start;
	logic                          clamp_pulse;
	logic                          start_hit;
	logic [vac_pkg::START_W-1:0]   pixel_count;

	modport ctrl  (output first_edge_lead, second_edge_lead, sync_select, start_count, pulse_length,
	               input clamp_start, clamp_pulse, start_hit, pixel_count);
	modport timer (input first_edge_lead, second_edge_lead, sync_select, start_count, pulse_length,
	               output clamp_start, clamp_pulse, start_hit, pixel_count);
endinterface : vac_clamp_if

// [hw/vac_clamp_timer.sv]
module vac_clamp_timer
(
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  sync1_in,
	input  wire logic  sync2_in,
	vac_clamp_if.timer cif
);

	logic                        sync_q;
	logic                        armed;
	logic [7:0]                  remain;
	logic                        sync_now;
	logic                        lead_sel;
	logic                        line_edge;
	logic [vac_pkg::START_W-1:0] count;

	// ---------------------------------------------------------------
	// edge selection
	// ---------------------------------------------------------------
	// sync is active high: leading edge rises, trailing edge falls
	assign sync_now  = cif.sync_select ? sync2_in : sync1_in;
	assign lead_sel  = cif.sync_select ? cif.second_edge_lead : cif.first_edge_lead;
	assign line_edge = lead_sel ? (sync_now & ~sync_q) : (~sync_now & sync_q);

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			sync_q <= 1'b0;
		else
			sync_q <= sync_now;
	end

	// pixel counter restarts at the selected edge and saturates
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			count <= '0;
		else if (line_edge)
			count <= '0;
		else if (count != '1)
			count <= count + 1'b1;
	end

	// one start per line; armed stops a late register write from firing twice
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			armed <= 1'b0;
		else if (line_edge)
			armed <= 1'b1;
		else if (cif.start_hit)
			armed <= 1'b0;
	end

	assign cif.start_hit   = armed & ~line_edge & (count == cif.start_count);
	assign cif.clamp_start = cif.start_hit & (cif.pulse_length >= vac_pkg::MIN_PULSE_WIDTH);
	assign cif.pixel_count = count;

	// clamp pulse length, counted down from the programmed width
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			remain <= 8'h00;
		else if (cif.clamp_start)
			remain <= cif.pulse_length;
		else if (remain != 8'h00)
			remain <= remain - 8'h01;
	end

	assign cif.clamp_pulse = (remain != 8'h00);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_pulse_begin;
		cif.clamp_start ##1 cif.clamp_pulse;
	endsequence

	AST_NARROW_NO_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cif.start_hit && cif.pulse_length < vac_pkg::MIN_PULSE_WIDTH |=> remain == $past(remain) - 8'h01 || remain == 8'h00)
		else $error("clamp pulse started with width below two");
	AST_PULSE_BEGINS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cif.clamp_start |-> s_pulse_begin)
		else $error("clamp pulse did not begin after start");
	AST_PULSE_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cif.clamp_start |=> remain == $past(cif.pulse_length))
		else $error("clamp pulse width not loaded");
	AST_START_POS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(armed) ##1 (count == cif.start_count && !line_edge) |-> cif.start_hit)
		else $error("start count reached without start");

endmodule : vac_clamp_timer

// [hw/vac_sync_clamp_ctrl.sv]
// Summary of operation
// - bit 0 picks leading or trailing edge of first line sync.
// - bit 2 picks leading or trailing edge of second line sync.
// - pin-disable bit forces the multipurpose input low internally.
// - bits 5..4 route the multipurpose input: invert, clamp, coast, pixel clock.
// - each clamp pulse restores, starts calibration if enabled, loads offsets.
// - with external clamp, offsets load on its leading edge, or when the fallback wait runs out.
// - without internal clamp, pending gain/offset loads within 100 ms.
// - bit 6 selects crystal frequency or half of it on aux output.
// - bit 7 holds the aux clock output low.
// - 13-bit start count, split high/low, delays restore after sync edge.
// - 8-bit clamp width sets restore pulse; calibration unaffected.
// - width 0x00 or 0x01 produces no clamp pulse.
// - calibration-disable bit turns black-level calibration off.
// - bits 3..2 set pixels averaged per line: 16 to 128.
// - time constant is 2 to the (5 + code) lines.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
module vac_sync_clamp_ctrl
#(
	parameter int UPDATE_DELAY = vac_pkg::UPDATE_DELAY_CYCLES
)
(
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RST_N_IN,
	input  wire logic [7:0]  S_AXI_AWADDR_IN,
	input  wire logic        S_AXI_AWVALID_IN,
	output logic             S_AXI_AWREADY_OUT,
	input  wire logic [31:0] S_AXI_WDATA_IN,
	input  wire logic [3:0]  S_AXI_WSTRB_IN,
	input  wire logic        S_AXI_WVALID_IN,
	output logic             S_AXI_WREADY_OUT,
	output logic [1:0]       S_AXI_BRESP_OUT,
	output logic             S_AXI_BVALID_OUT,
	input  wire logic        S_AXI_BREADY_IN,
	input  wire logic [7:0]  S_AXI_ARADDR_IN,
	input  wire logic        S_AXI_ARVALID_IN,
	output logic             S_AXI_ARREADY_OUT,
	output logic [31:0]      S_AXI_RDATA_OUT,
	output logic [1:0]       S_AXI_RRESP_OUT,
	output logic             S_AXI_RVALID_OUT,
	input  wire logic        S_AXI_RREADY_IN,
	input  wire logic        FIRST_LINE_SYNC_INPUT_IN,
	input  wire logic        SECOND_LINE_SYNC_INPUT_IN,
	input  wire logic        LINE_SYNC_SELECT_IN,
	input  wire logic        MULTIPURPOSE_INPUT_PIN_IN,
	input  wire logic        CRYSTAL_CLOCK_IN,
	input  wire logic        RESTORE_ENABLE_IN,
	input  wire logic        GAIN_OFFSET_WRITE_IN,
	output logic             SAMPLE_CLOCK_INVERT_OUT,
	output logic             EXTERNAL_COAST_OUT,
	output logic             EXTERNAL_SAMPLE_CLOCK_OUT,
	output logic             AUX_CRYSTAL_CLOCK_OUT,
	output logic             DC_RESTORE_PULSE_OUT,
	output logic             CALIB_START_OUT,
	output logic             OFFSET_LOAD_OUT,
	output logic             CALIB_ENABLE_OUT,
	output logic [7:0]       CALIB_PIXELS_OUT,
	output logic [12:0]      CALIB_LINES_OUT
);

	vac_clamp_if cif ();

	logic [7:0]  reg_sync_aux;
	logic [7:0]  reg_start_high;
	logic [7:0]  reg_start_low;
	logic [7:0]  reg_pulse_width;
	logic [7:0]  reg_calib;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        have_aw;
	logic        have_w;
	logic        do_write;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_lane0;
	logic        rd_take;
	logic [31:0] next_rdata;
	logic        next_rbad;
	logic        pin_eff;
	logic        pin_eff_q;
	logic        ext_clamp_mode;
	logic        ext_clamp_rise;
	logic        internal_clamp;
	logic        pending;
	logic [31:0] wait_count;
	logic        wait_done;
	logic        load_now;
	logic        crystal_q;
	logic        crystal_half;
	vac_pkg::vac_pin_func_t pin_func;

	// ---------------------------------------------------------------
	// axi4-lite write channel
	// ---------------------------------------------------------------
	// address and data are taken in either order; the write happens once both are held
	assign S_AXI_AWREADY_OUT = !aw_got && !S_AXI_BVALID_OUT;
	assign S_AXI_WREADY_OUT  = !w_got && !S_AXI_BVALID_OUT;
	assign have_aw  = aw_got || (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT);
	assign have_w   = w_got || (S_AXI_WVALID_IN && S_AXI_WREADY_OUT);
	assign do_write = have_aw && have_w;
	assign wr_addr  = aw_got ? aw_addr_q : S_AXI_AWADDR_IN;
	assign wr_data  = w_got ? w_data_q : S_AXI_WDATA_IN;
	assign wr_strb  = w_got ? w_strb_q : S_AXI_WSTRB_IN;
	assign wr_lane0 = do_write && wr_strb[0];

	// hold whichever half arrived first
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			aw_got    <= 1'b0;
			w_got     <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
		end
		else
		begin
			aw_got <= have_aw && !do_write;
			w_got  <= have_w && !do_write;
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
				aw_addr_q <= S_AXI_AWADDR_IN;
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
			begin
				w_data_q <= S_AXI_WDATA_IN;
				w_strb_q <= S_AXI_WSTRB_IN;
			end
		end
	end

	// write response; unmapped or status address answers slave error
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT  <= vac_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			S_AXI_BVALID_OUT <= 1'b1;
			S_AXI_BRESP_OUT  <= (wr_addr < vac_pkg::ADDR_STATUS && wr_addr[1:0] == 2'b00) ?
			                    vac_pkg::RESP_OKAY : vac_pkg::RESP_SLVERR;
		end
		else if (S_AXI_BREADY_IN)
			S_AXI_BVALID_OUT <= 1'b0;
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	// only byte lane 0 carries data; upper bits are reserved
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			reg_sync_aux    <= vac_pkg::RST_SYNC_AUX;
			reg_start_high  <= vac_pkg::RST_START_HIGH;
			reg_start_low   <= vac_pkg::RST_START_LOW;
			reg_pulse_width <= vac_pkg::RST_PULSE_WIDTH;
			reg_calib       <= vac_pkg::RST_CALIB_CONFIG;
		end
		else if (wr_lane0)
		begin
			unique case (wr_addr)
				vac_pkg::ADDR_SYNC_AUX:     reg_sync_aux    <= wr_data[7:0] & vac_pkg::MASK_SYNC_AUX;
				vac_pkg::ADDR_START_HIGH:   reg_start_high  <= wr_data[7:0] & vac_pkg::MASK_START_HIGH;
				vac_pkg::ADDR_START_LOW:    reg_start_low   <= wr_data[7:0] & vac_pkg::MASK_START_LOW;
				vac_pkg::ADDR_PULSE_WIDTH:  reg_pulse_width <= wr_data[7:0] & vac_pkg::MASK_PULSE_WIDTH;
				vac_pkg::ADDR_CALIB_CONFIG: reg_calib       <= wr_data[7:0] & vac_pkg::MASK_CALIB_CONFIG;
				default:                    ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite read channel
	// ---------------------------------------------------------------
	assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
	assign rd_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;

	// read mux; status shows the live pixel count and the pending offset load
	always_comb
	begin
		next_rdata = 32'h00000000;
		next_rbad  = 1'b0;
		unique case (S_AXI_ARADDR_IN)
			vac_pkg::ADDR_SYNC_AUX:     next_rdata[7:0] = reg_sync_aux;
			vac_pkg::ADDR_START_HIGH:   next_rdata[7:0] = reg_start_high;
			vac_pkg::ADDR_START_LOW:    next_rdata[7:0] = reg_start_low;
			vac_pkg::ADDR_PULSE_WIDTH:  next_rdata[7:0] = reg_pulse_width;
			vac_pkg::ADDR_CALIB_CONFIG: next_rdata[7:0] = reg_calib;
			vac_pkg::ADDR_STATUS:       next_rdata[15:0] = {pending, DC_RESTORE_PULSE_OUT, 1'b0, cif.pixel_count};
			default:                    next_rbad = 1'b1;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT  <= 32'h00000000;
			S_AXI_RRESP_OUT  <= vac_pkg::RESP_OKAY;
		end
		else if (rd_take)
		begin
			S_AXI_RVALID_OUT <= 1'b1;
			S_AXI_RDATA_OUT  <= next_rdata;
			S_AXI_RRESP_OUT  <= next_rbad ? vac_pkg::RESP_SLVERR : vac_pkg::RESP_OKAY;
		end
		else if (S_AXI_RREADY_IN)
			S_AXI_RVALID_OUT <= 1'b0;
	end

	// ---------------------------------------------------------------
	// clamp timer
	// ---------------------------------------------------------------
	assign cif.first_edge_lead  = reg_sync_aux[vac_pkg::FIRST_EDGE_BIT];
	assign cif.second_edge_lead = reg_sync_aux[vac_pkg::SECOND_EDGE_BIT];
	assign cif.sync_select      = LINE_SYNC_SELECT_IN;
	assign cif.start_count      = {reg_start_high[vac_pkg::START_HIGH_W-1:0], reg_start_low};
	assign cif.pulse_length     = reg_pulse_width;

	vac_clamp_timer u_timer
	(
		.clk_in   (CLK_SYS_IN),
		.rst_n_in (RST_N_IN),
		.sync1_in (FIRST_LINE_SYNC_INPUT_IN),
		.sync2_in (SECOND_LINE_SYNC_INPUT_IN),
		.cif      (cif)
	);

	// ---------------------------------------------------------------
	// multipurpose pin routing
	// ---------------------------------------------------------------
	assign pin_eff  = MULTIPURPOSE_INPUT_PIN_IN & ~reg_sync_aux[vac_pkg::PIN_DISABLE_BIT];
	assign pin_func = vac_pkg::vac_pin_func_t'(reg_sync_aux[vac_pkg::PIN_FUNC_LSB +: 2]);
	assign ext_clamp_mode = (pin_func == vac_pkg::VAC_FUNC_CLAMP);
	assign ext_clamp_rise = ext_clamp_mode && pin_eff && !pin_eff_q;
	// an external clamp replaces the internal one
	assign internal_clamp = !ext_clamp_mode && (reg_pulse_width >= vac_pkg::MIN_PULSE_WIDTH);

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			pin_eff_q                 <= 1'b0;
			SAMPLE_CLOCK_INVERT_OUT   <= 1'b0;
			EXTERNAL_COAST_OUT        <= 1'b0;
			EXTERNAL_SAMPLE_CLOCK_OUT <= 1'b0;
		end
		else
		begin
			pin_eff_q                 <= pin_eff;
			SAMPLE_CLOCK_INVERT_OUT   <= pin_eff && pin_func == vac_pkg::VAC_FUNC_INVERT;
			EXTERNAL_COAST_OUT        <= pin_eff && pin_func == vac_pkg::VAC_FUNC_COAST;
			EXTERNAL_SAMPLE_CLOCK_OUT <= pin_eff && pin_func == vac_pkg::VAC_FUNC_EXTERNAL_SAMPLE_CLOCK;
		end
	end

	// ---------------------------------------------------------------
	// clamp actions
	// ---------------------------------------------------------------
	// restore rides the internal pulse or the external clamp; calibration start rides the start hit or the external clamp edge
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			DC_RESTORE_PULSE_OUT <= 1'b0;
			CALIB_START_OUT      <= 1'b0;
		end
		else
		begin
			DC_RESTORE_PULSE_OUT <= RESTORE_ENABLE_IN &&
			                        (ext_clamp_mode ? pin_eff : cif.clamp_pulse);
			// calibration is timed by the start count (external clamp: its rising edge), never by the clamp width
			CALIB_START_OUT      <= !reg_calib[vac_pkg::CALIB_DIS_BIT] &&
			                        (ext_clamp_mode ? ext_clamp_rise : cif.start_hit);
		end
	end

	// fallback wait, only counted while a load is pending
	assign wait_done = (wait_count == 32'(UPDATE_DELAY - 1));
	assign load_now  = (ext_clamp_mode ? ext_clamp_rise : cif.clamp_start) || (pending && wait_done);

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			wait_count <= 32'h00000000;
		else if (!pending || load_now)
			wait_count <= 32'h00000000;
		else
			wait_count <= wait_count + 32'h00000001;
	end

	// a write landing with a load keeps the flag: set wins over clear
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			pending <= 1'b0;
		else if (GAIN_OFFSET_WRITE_IN)
			pending <= 1'b1;
		else if (load_now)
			pending <= 1'b0;
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			OFFSET_LOAD_OUT <= 1'b0;
		else
			OFFSET_LOAD_OUT <= load_now;
	end

	// ---------------------------------------------------------------
	// auxiliary crystal clock
	// ---------------------------------------------------------------
	// crystal is sampled, so it must run below half the system clock
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			crystal_q    <= 1'b0;
			crystal_half <= 1'b0;
		end
		else
		begin
			crystal_q <= CRYSTAL_CLOCK_IN;
			if (CRYSTAL_CLOCK_IN && !crystal_q)
				crystal_half <= !crystal_half;
		end
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
			AUX_CRYSTAL_CLOCK_OUT <= 1'b0;
		else if (reg_sync_aux[vac_pkg::AUX_DISABLE_BIT])
			AUX_CRYSTAL_CLOCK_OUT <= 1'b0;
		else
			AUX_CRYSTAL_CLOCK_OUT <= reg_sync_aux[vac_pkg::AUX_DIVIDE_BIT] ? crystal_half : CRYSTAL_CLOCK_IN;
	end

	// ---------------------------------------------------------------
	// calibration configuration
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RST_N_IN)
		begin
			CALIB_ENABLE_OUT <= 1'b0;
			CALIB_PIXELS_OUT <= 8'h00;
			CALIB_LINES_OUT  <= 13'h0000;
		end
		else
		begin
			CALIB_ENABLE_OUT <= !reg_calib[vac_pkg::CALIB_DIS_BIT];
			CALIB_PIXELS_OUT <= vac_pkg::calib_pixels(reg_calib[vac_pkg::CALIB_PIX_LSB +: 2]);
			CALIB_LINES_OUT  <= vac_pkg::calib_lines(reg_calib[vac_pkg::CALIB_TC_LSB +: 3]);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_ext_edge;
		ext_clamp_mode && pin_eff && !pin_eff_q;
	endsequence

	AST_PIN_FORCED_LOW: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		reg_sync_aux[vac_pkg::PIN_DISABLE_BIT] |=> !SAMPLE_CLOCK_INVERT_OUT && !EXTERNAL_COAST_OUT)
		else $error("disabled pin still reaches an output");
	AST_EXT_LOAD: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		s_ext_edge |=> OFFSET_LOAD_OUT)
		else $error("external clamp edge did not load offsets");
	AST_EXT_ONLY_EDGE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		ext_clamp_mode && !ext_clamp_rise && !(pending && wait_done) |=> !OFFSET_LOAD_OUT)
		else $error("offset load outside external clamp edge");
	AST_INT_LOAD: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		!ext_clamp_mode && cif.clamp_start |=> OFFSET_LOAD_OUT)
		else $error("clamp pulse did not load offsets");
	AST_UPDATE_BOUND: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		wait_count < 32'(UPDATE_DELAY))
		else $error("pending load waited too long");
	AST_AUX_LOW: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		reg_sync_aux[vac_pkg::AUX_DISABLE_BIT] ##1 reg_sync_aux[vac_pkg::AUX_DISABLE_BIT] |-> !AUX_CRYSTAL_CLOCK_OUT)
		else $error("aux clock toggles while disabled");
	AST_CALIB_OFF: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		reg_calib[vac_pkg::CALIB_DIS_BIT] |=> !CALIB_START_OUT)
		else $error("calibration started while disabled");
	AST_RESERVED_ZERO: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		rd_take && S_AXI_ARADDR_IN != vac_pkg::ADDR_STATUS |=> S_AXI_RDATA_OUT[31:8] == 24'h000000)
		else $error("reserved read bits not zero");
	AST_LINES: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
		$stable(reg_calib) |=> CALIB_LINES_OUT == (13'h0020 << $past(reg_calib[vac_pkg::CALIB_TC_LSB +: 3])))
		else $error("time constant wrong");

endmodule : vac_sync_clamp_ctrl

// [tb/vac_src.sv]
module vac_src
(
	input  wire logic clk_in,
	input  wire logic run_in,
	output logic      sync1_out,
	output logic      sync2_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] pos = 7'h00;
	// 128-pixel lines; both syncs idle low while stopped so no stray edge appears between runs
	always_ff @(posedge clk_in) pos <= run_in ? pos + 7'h01 : 7'h00;
	assign sync1_out = run_in && (pos < 7'h08);
	assign sync2_out = run_in && (pos >= 7'h40) && (pos < 7'h48);
endmodule : vac_src

// [tb/vac_sync_clamp_ctrl_test.sv]
module vac_sync_clamp_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_SYS_IN = 0, RST_N_IN = 0, run = 0;
	logic [1:0]  xc = 2'h0;
	logic [7:0]  S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00, CALIB_PIXELS_OUT;
	logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT;
	logic [3:0]  S_AXI_WSTRB_IN = 4'hF;
	logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
	logic        S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0, S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
	logic        LINE_SYNC_SELECT_IN = 0, MULTIPURPOSE_INPUT_PIN_IN = 0, RESTORE_ENABLE_IN = 1, GAIN_OFFSET_WRITE_IN = 0;
	logic        S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
	logic        SAMPLE_CLOCK_INVERT_OUT, EXTERNAL_COAST_OUT, EXTERNAL_SAMPLE_CLOCK_OUT, AUX_CRYSTAL_CLOCK_OUT;
	logic        DC_RESTORE_PULSE_OUT, CALIB_START_OUT, OFFSET_LOAD_OUT, CALIB_ENABLE_OUT;
	logic [12:0] CALIB_LINES_OUT;
	wire         FIRST_LINE_SYNC_INPUT_IN, SECOND_LINE_SYNC_INPUT_IN;
	wire         CRYSTAL_CLOCK_IN = xc[1];
	int          fail_count = 0, checked = 0;
	// short pending delay keeps the forced-load case within a few dozen cycles
	vac_sync_clamp_ctrl #(.UPDATE_DELAY(20)) u_vac_sync_clamp_ctrl (.*);
	vac_src u_vac_src (.clk_in(CLK_SYS_IN), .run_in(run), .sync1_out(FIRST_LINE_SYNC_INPUT_IN),
		.sync2_out(SECOND_LINE_SYNC_INPUT_IN));
	// crystal at a quarter of the system clock, well under the sampling limit
	always @(posedge CLK_SYS_IN) xc <= xc + 2'h1;
	initial forever #5 CLK_SYS_IN = ~CLK_SYS_IN;
	task automatic give_verdict;
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one bus transfer; address and data offered together, each dropped once taken
	task automatic axi(input logic rd, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		// one idle edge keeps the previous call's ready release apart from this call's raise
		@(posedge CLK_SYS_IN);
		S_AXI_AWADDR_IN <= a;
		S_AXI_ARADDR_IN <= a;
		S_AXI_WDATA_IN <= wd;
		S_AXI_AWVALID_IN <= !rd;
		S_AXI_WVALID_IN <= !rd;
		S_AXI_BREADY_IN <= !rd;
		S_AXI_ARVALID_IN <= rd;
		S_AXI_RREADY_IN <= rd;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK_SYS_IN);
			if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 0;
			if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 0;
			if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 0;
			if (rd ? S_AXI_RVALID_OUT : S_AXI_BVALID_OUT) break;
		end
		d = S_AXI_RDATA_OUT;
		r = rd ? S_AXI_RRESP_OUT : S_AXI_BRESP_OUT;
		S_AXI_BREADY_IN <= 0;
		S_AXI_RREADY_IN <= 0;
		if (n == 50) fail_count++;
		if (n == 50) give_verdict();
	endtask : axi
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axi(1'b0, a, v, d, r);
		chk(r, er);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi(1'b1, a, 32'h0, d, r);
		chk(d, e);
	endtask : rdc
	// run two lines; first is the cycle count from start to the first restore output cycle
	task automatic clamp(input logic [7:0] ctrl, input logic [7:0] w, input int first, input int cnt);
		int k, f, n, c;
		f = 0;
		n = 0;
		c = 0;
		wr(vac_pkg::ADDR_SYNC_AUX, 32'(ctrl), vac_pkg::RESP_OKAY);
		wr(vac_pkg::ADDR_PULSE_WIDTH, 32'(w), vac_pkg::RESP_OKAY);
		run <= 1;
		for (k = 1; k <= 256; k++)
		begin
			@(posedge CLK_SYS_IN);
			if (DC_RESTORE_PULSE_OUT === 1'b1 && f == 0) f = k;
			n += (DC_RESTORE_PULSE_OUT === 1'b1);
			c += (CALIB_START_OUT === 1'b1);
		end
		run <= 0;
		chk(f, first);
		chk(n, cnt);
		chk(c, 2);
	endtask : clamp
	// pin routing per function code, then pin disabled with the aux clock held low
	task automatic pins;
		logic [2:0] exp [5] = '{3'b100, 3'b000, 3'b010, 3'b001, 3'b000};
		int i, n;
		n = 0;
		MULTIPURPOSE_INPUT_PIN_IN <= 1;
		for (i = 0; i < 5; i++)
		begin
			wr(vac_pkg::ADDR_SYNC_AUX, i < 4 ? 32'(i) << 4 : 32'h88, vac_pkg::RESP_OKAY);
			repeat (3) @(posedge CLK_SYS_IN);
			chk({SAMPLE_CLOCK_INVERT_OUT, EXTERNAL_COAST_OUT, EXTERNAL_SAMPLE_CLOCK_OUT}, exp[i]);
		end
		repeat (12) @(posedge CLK_SYS_IN) n += (AUX_CRYSTAL_CLOCK_OUT !== 1'b0);
		chk(n, 0);
		GAIN_OFFSET_WRITE_IN <= 1;
		@(posedge CLK_SYS_IN);
		GAIN_OFFSET_WRITE_IN <= 0;
		repeat (40) @(posedge CLK_SYS_IN) n += (OFFSET_LOAD_OUT === 1'b1);
		chk(n, 1);
		// external clamp: offsets load once, on the rising edge of the pin only
		MULTIPURPOSE_INPUT_PIN_IN <= 0;
		wr(vac_pkg::ADDR_SYNC_AUX, 32'h10, vac_pkg::RESP_OKAY);
		MULTIPURPOSE_INPUT_PIN_IN <= 1;
		n = 0;
		repeat (6) @(posedge CLK_SYS_IN) n += (OFFSET_LOAD_OUT === 1'b1);
		chk(n, 1);
	endtask : pins
	// calibration fields and masking of reserved bits
	task automatic fields;
		logic [31:0] v;
		int i;
		wr(vac_pkg::ADDR_SYNC_AUX, 32'hFFFFFFFF, vac_pkg::RESP_OKAY);
		rdc(vac_pkg::ADDR_SYNC_AUX, 32'h000000FD);
		wr(8'h18, 32'h1, vac_pkg::RESP_SLVERR);
		for (i = 0; i < 4; i++)
		begin
			v = 32'(i * 4 + (i + 4) * 16 + 1);
			wr(vac_pkg::ADDR_CALIB_CONFIG, v, vac_pkg::RESP_OKAY);
			repeat (2) @(posedge CLK_SYS_IN);
			chk({CALIB_ENABLE_OUT, CALIB_PIXELS_OUT, CALIB_LINES_OUT}, {1'b0, 8'(16 << i), 13'(512 << i)});
			rdc(vac_pkg::ADDR_CALIB_CONFIG, v);
		end
	endtask : fields
	initial
	begin
		repeat (2) @(posedge CLK_SYS_IN);
		RST_N_IN <= 1;
		rdc(vac_pkg::ADDR_CALIB_CONFIG, 32'h40);
		chk({CALIB_ENABLE_OUT, CALIB_PIXELS_OUT, CALIB_LINES_OUT}, {1'b1, 8'h10, 13'h0200});
		wr(vac_pkg::ADDR_START_LOW, 32'h0A, vac_pkg::RESP_OKAY);
		wr(vac_pkg::ADDR_START_HIGH, 32'h0, vac_pkg::RESP_OKAY);
		clamp(8'h00, 8'h04, 22, 8);
		clamp(8'h01, 8'h04, 14, 8);
		clamp(8'h00, 8'h02, 22, 4);
		clamp(8'h00, 8'h01, 0, 0);
		// second sync input, leading edge; its pulse sits half a line later
		LINE_SYNC_SELECT_IN <= 1;
		clamp(8'h04, 8'h04, 78, 8);
		pins();
		fields();
		give_verdict();
	end
endmodule : vac_sync_clamp_ctrl_test
